/* core/cfg_bank_if.sv */
// Write port and register contents between the decoder and the register bank.
`timescale 1ns/1ps
interface cfg_bank_if;
  logic we;
  logic [pin_select_pkg::IDX_W-1:0] widx;
  logic [7:0] wdata;
  logic [pin_select_pkg::NUM_REGS-1:0][7:0] regs;

  modport ctrl (output we, output widx, output wdata, input regs);
  modport bank (input we, input widx, input wdata, output regs);
endinterface

/* core/cfg_reg_bank.sv */
// Bank of write-only direction and function-select registers.
`timescale 1ns/1ps
module cfg_reg_bank (
  input wire logic mclk_i,
  input wire logic rst_i,
  cfg_bank_if.bank cfg
);

  // ==========================================================================
  // One byte register per bank entry
  // Unimplemented bits are masked on write so they always hold zero.
  for (genvar i = 0; i < pin_select_pkg::NUM_REGS; i++) begin : g_reg
    localparam logic [pin_select_pkg::IDX_W-1:0] BANK_IDX = pin_select_pkg::IDX_W'(i);
    logic [7:0] val_q;

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        val_q <= pin_select_pkg::REG_RESET;
      end else if (cfg.we && (cfg.widx == BANK_IDX)) begin
        val_q <= cfg.wdata & pin_select_pkg::WMASK[i];
      end
    end

    assign cfg.regs[i] = val_q;
  end

endmodule

/* core/pin_select_pkg.sv */
// Shared constants for the port pin direction and function-select block.
package pin_select_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_REGS = 16;
  localparam int NUM_SLOTS = 9;
  localparam int IDX_W = 4;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_PORT0_DIR = 8'h02;
  localparam logic [7:0] OFF_PORT2_DIR = 8'h08;
  localparam logic [7:0] OFF_PORT2_FUNC = 8'h09;
  localparam logic [7:0] OFF_PORT3_DIR = 8'h0A;
  localparam logic [7:0] OFF_PORT3_FUNC = 8'h0B;
  localparam logic [7:0] OFF_PORT4_DIR = 8'h0E;
  localparam logic [7:0] OFF_PORT4_FUNC = 8'h0F;
  localparam logic [7:0] OFF_PORT5_DIR = 8'h10;
  localparam logic [7:0] OFF_PORT5_FUNC = 8'h11;
  localparam logic [7:0] OFF_PORT6_FUNC = 8'h15;
  localparam logic [7:0] OFF_PORT7_DIR = 8'h16;
  localparam logic [7:0] OFF_PORT7_FUNC = 8'h17;
  localparam logic [7:0] OFF_PORT8_DIR = 8'h1A;
  localparam logic [7:0] OFF_PORT8_FUNC = 8'h1B;
  localparam logic [7:0] OFF_PORT9_DIR = 8'h1C;
  localparam logic [7:0] OFF_PORT9_FUNC = 8'h1D;
  localparam logic [7:0] OFF_STATUS = 8'h3F;

  // Register index order in the bank.
  localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
    OFF_PORT0_DIR, OFF_PORT2_DIR, OFF_PORT2_FUNC, OFF_PORT3_DIR,
    OFF_PORT3_FUNC, OFF_PORT4_DIR, OFF_PORT4_FUNC, OFF_PORT5_DIR,
    OFF_PORT5_FUNC, OFF_PORT6_FUNC, OFF_PORT7_DIR, OFF_PORT7_FUNC,
    OFF_PORT8_DIR, OFF_PORT8_FUNC, OFF_PORT9_DIR, OFF_PORT9_FUNC};

  // ==========================================================================
  // Implemented bits of each register, in bank order
  localparam logic [7:0] WMASK [NUM_REGS] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC,
    8'h9F, 8'h0F, 8'h3F, 8'h36, 8'hFF, 8'h6D, 8'h7F, 8'hCF};
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Per pin slot: slots 0..8 are ports 0, 2, 3, 4, 5, 6, 7, 8, 9
  localparam int SLOT_PORT0 = 0;
  localparam int SLOT_PORT3 = 2;
  localparam int SLOT_PORT4 = 3;
  localparam int SLOT_PORT5 = 4;
  localparam int SLOT_PORT8 = 7;
  localparam int SLOT_PORT9 = 8;
  localparam int DIR_IDX [NUM_SLOTS] = '{0, 1, 3, 5, 7, 0, 10, 12, 14};
  localparam int FUNC_IDX [NUM_SLOTS] = '{0, 2, 4, 6, 8, 9, 11, 13, 15};
  localparam logic [7:0] DIR_MASK [NUM_SLOTS] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'h00, 8'h3F, 8'hFF, 8'h7F};
  localparam logic [7:0] FUNC_MASK [NUM_SLOTS] = '{
    8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h9F, 8'h0F, 8'h36, 8'h6D, 8'hCF};
  // Pins taken over by the bus in the external-ROM variant.
  localparam logic [7:0] FORCE_MASK [NUM_SLOTS] = '{
    8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};

  // ==========================================================================
  // Status register fields
  localparam int ST_EXT_ROM = 0;
  localparam int ST_ADDR_ROLE = 1;
  localparam int ST_STROBE_ROLE = 2;

endpackage

/* core/port_pin_function_select.sv */
// Direction and function-select logic for the parallel port pins.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
// ============================================================================
// Overview of operation
// - External-ROM variant: port 0 always data bus.
// - External-ROM variant: ports 3, 4 drive address.
// - External-ROM variant: port 5 pins 0, 1 strobe outputs.
// - Forced bus roles override direction, function writes.
// ============================================================================
module port_pin_function_select #(
  parameter bit EXT_ROM_VARIANT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  input wire logic bus_dout_en_i,
  input wire logic [8:0][7:0] port_data_i,
  input wire logic [8:0][7:0] alt_data_i,
  output logic [8:0][7:0] pin_do_o,
  output logic [8:0][7:0] pin_oe_o,
  output logic [8:0][7:0] func_sel_o,
  output logic data_bus_mode_o
);

  // ==========================================================================
  // Address decode

  // Returns the hit flag in the top bit and the bank index below it.
  function automatic logic [pin_select_pkg::IDX_W:0] reg_lookup(
    input logic [7:0] a
  );
    logic [pin_select_pkg::IDX_W:0] r;
    r = '0;
    for (int i = 0; i < pin_select_pkg::NUM_REGS; i++) begin
      if (a == pin_select_pkg::REG_OFFSET[i]) begin
        r = {1'b1, i[pin_select_pkg::IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  logic [pin_select_pkg::IDX_W:0] wr_hit;
  logic ext_rom;

  assign wr_hit = reg_lookup(addr_i);
  assign ext_rom = EXT_ROM_VARIANT;

  // ==========================================================================
  // Register bank

  cfg_bank_if cfg ();

  // Writes reach the bank whatever the variant; forcing is applied downstream
  // so a later variant change would still see software's values.
  assign cfg.we = wr_i && wr_hit[pin_select_pkg::IDX_W];
  assign cfg.widx = wr_hit[pin_select_pkg::IDX_W-1:0];
  assign cfg.wdata = wr_data_i;

  cfg_reg_bank u_bank (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cfg(cfg)
  );

  // ==========================================================================
  // Per-slot pin resolution

  logic [8:0][7:0] oe_d;
  logic [8:0][7:0] func_d;
  logic [8:0][7:0] do_d;

  for (genvar s = 0; s < pin_select_pkg::NUM_SLOTS; s++) begin : g_slot
    logic [7:0] raw_dir;
    logic [7:0] raw_func;
    logic [7:0] nat_oe;
    logic [7:0] forced;
    logic [7:0] force_oe;

    // Pins with no direction bit drive exactly when their shared role is on.
    assign raw_dir = cfg.regs[pin_select_pkg::DIR_IDX[s]] & pin_select_pkg::DIR_MASK[s];
    assign raw_func = cfg.regs[pin_select_pkg::FUNC_IDX[s]] & pin_select_pkg::FUNC_MASK[s];
    assign nat_oe = raw_dir | (raw_func & ~pin_select_pkg::DIR_MASK[s]);

    assign forced = ext_rom ? pin_select_pkg::FORCE_MASK[s] : 8'h00;

    // The data bus turns round under bus control; address and strobes always drive.
    if (s == pin_select_pkg::SLOT_PORT0) begin : g_data_bus
      assign force_oe = {8{bus_dout_en_i}};
    end else begin : g_addr_strobe
      assign force_oe = 8'hFF;
    end

    assign oe_d[s] = (nat_oe & ~forced) | (forced & force_oe);
    assign func_d[s] = (raw_func & ~forced) | forced;
    assign do_d[s] = (func_d[s] & alt_data_i[s]) | (~func_d[s] & port_data_i[s]);
  end

  // ==========================================================================
  // Pin outputs

  logic [8:0][7:0] pin_do_q;
  logic [8:0][7:0] pin_oe_q;
  logic [8:0][7:0] func_sel_q;

  // A register stage on the pin side keeps the decode glitch-free at the pads.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_oe_q <= '0;
    end else begin
      pin_oe_q <= oe_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      func_sel_q <= '0;
    end else begin
      func_sel_q <= func_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_do_q <= '0;
    end else begin
      pin_do_q <= do_d;
    end
  end

  assign pin_do_o = pin_do_q;
  assign pin_oe_o = pin_oe_q;
  assign func_sel_o = func_sel_q;
  assign data_bus_mode_o = ext_rom;

  // ==========================================================================
  // Status and read-back

  logic [7:0] status;
  logic [7:0] rd_data_q;

  always_comb begin
    status = 8'h00;
    status[pin_select_pkg::ST_EXT_ROM] = ext_rom;
    status[pin_select_pkg::ST_ADDR_ROLE] =
      |{func_sel_q[pin_select_pkg::SLOT_PORT3], func_sel_q[pin_select_pkg::SLOT_PORT4]};
    status[pin_select_pkg::ST_STROBE_ROLE] = |func_sel_q[pin_select_pkg::SLOT_PORT5][1:0];
  end

  // The control registers are write-only, so only the status word reads back.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_data_q <= 8'h00;
    end else if (rd_i && (addr_i == pin_select_pkg::OFF_STATUS)) begin
      rd_data_q <= status;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data_o = rd_data_q;

  // ==========================================================================
  // Checks

  a_port0_data_bus: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ext_rom && !$past(rst_i)) |=>
      (func_sel_o[pin_select_pkg::SLOT_PORT0] == 8'hFF)
      && (pin_oe_o[pin_select_pkg::SLOT_PORT0] == {8{$past(bus_dout_en_i)}})
  ) else $error("port 0 left the data bus role");

  a_port0_write_blocked: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT0_DIR && !bus_dout_en_i)
      ##1 !bus_dout_en_i |->
      ##1 pin_oe_o[pin_select_pkg::SLOT_PORT0] == 8'h00
  ) else $error("port 0 direction write reached the pins");

  a_addr_bus_drive: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ext_rom ##1 ext_rom |->
      (pin_oe_o[pin_select_pkg::SLOT_PORT3] == 8'hFF)
      && (pin_oe_o[pin_select_pkg::SLOT_PORT4] == 8'hFF)
      && (func_sel_o[pin_select_pkg::SLOT_PORT4] == 8'hFF)
  ) else $error("address bus pins not driven");

  a_addr_bus_data: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ext_rom |=>
      pin_do_o[pin_select_pkg::SLOT_PORT3] == $past(alt_data_i[pin_select_pkg::SLOT_PORT3])
  ) else $error("address bus does not carry the address");

  a_strobe_pins: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ext_rom |=>
      (pin_oe_o[pin_select_pkg::SLOT_PORT5][1:0] == 2'h3)
      && (pin_do_o[pin_select_pkg::SLOT_PORT5][1:0]
        == $past(alt_data_i[pin_select_pkg::SLOT_PORT5][1:0]))
  ) else $error("strobe pins not driven by the bus strobes");

  a_force_override: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT5_FUNC) |->
      ##2 (func_sel_o[pin_select_pkg::SLOT_PORT5][1:0] == 2'h3)
      && (func_sel_o[pin_select_pkg::SLOT_PORT5][7:2]
        == (($past(wr_data_i, 2) >> 2) & (pin_select_pkg::WMASK[8] >> 2)))
  ) else $error("strobe select write not overridden");

  a_dir_write_out: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT3_DIR)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT3_DIR) |->
      ##1 pin_oe_o[pin_select_pkg::SLOT_PORT3] == $past(wr_data_i, 2)
  ) else $error("direction write did not set the output enables");

  a_func_selects_alt: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    func_d[pin_select_pkg::SLOT_PORT8][0] |=>
      pin_do_o[pin_select_pkg::SLOT_PORT8][0] == $past(alt_data_i[pin_select_pkg::SLOT_PORT8][0])
  ) else $error("shared role bit did not select the role data");

  a_reset_inputs: assert property (
    @(posedge mclk_i)
    rst_i |=> (pin_oe_o[pin_select_pkg::SLOT_PORT9] == 8'h00)
      && (func_sel_o[pin_select_pkg::SLOT_PORT9] == 8'h00)
  ) else $error("pins not inputs after reset");

  a_status_read: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (rd_i && addr_i == pin_select_pkg::OFF_STATUS) |=>
      rd_data_o[pin_select_pkg::ST_EXT_ROM] == ext_rom
  ) else $error("status read wrong");

  a_wo_read_zero: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !(rd_i && addr_i == pin_select_pkg::OFF_STATUS) |=> rd_data_o == 8'h00
  ) else $error("read data outside a status read");

  // The checks below pin down the forced address and strobe roles and the plain write paths of ports 0, 4, 5, 8 and 9 on their own,
  // so a wrong mask shows up at the register that owns it.

  a_addr_func_forced: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ext_rom |=>
      (func_sel_o[pin_select_pkg::SLOT_PORT3] == 8'hFF)
      && (pin_do_o[pin_select_pkg::SLOT_PORT4]
        == $past(alt_data_i[pin_select_pkg::SLOT_PORT4]))
  ) else $error("address pins left the address role");

  a_strobe_func_forced: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ext_rom |=> func_sel_o[pin_select_pkg::SLOT_PORT5][1:0] == 2'h3
  ) else $error("strobe pins left the strobe role");

  a_port3_write_ignored: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ext_rom && wr_i
      && (addr_i == pin_select_pkg::OFF_PORT3_DIR || addr_i == pin_select_pkg::OFF_PORT3_FUNC))
      |-> ##2 ((pin_oe_o[pin_select_pkg::SLOT_PORT3] == 8'hFF)
      && (func_sel_o[pin_select_pkg::SLOT_PORT3] == 8'hFF))
  ) else $error("port 3 write reached the address pins");

  a_port4_write_ignored: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ext_rom && wr_i
      && (addr_i == pin_select_pkg::OFF_PORT4_DIR || addr_i == pin_select_pkg::OFF_PORT4_FUNC))
      |-> ##2 ((pin_oe_o[pin_select_pkg::SLOT_PORT4] == 8'hFF)
      && (func_sel_o[pin_select_pkg::SLOT_PORT4] == 8'hFF))
  ) else $error("port 4 write reached the address pins");

  a_port0_dir_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT0_DIR)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT0_DIR) |->
      ##1 pin_oe_o[pin_select_pkg::SLOT_PORT0] == $past(wr_data_i, 2)
  ) else $error("port 0 direction write did not reach the pins");

  a_port4_dir_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT4_DIR)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT4_DIR) |->
      ##1 pin_oe_o[pin_select_pkg::SLOT_PORT4] == $past(wr_data_i, 2)
  ) else $error("port 4 direction write did not reach the pins");

  a_port8_dir_out: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT8_DIR)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT8_DIR) |->
      ##1 pin_oe_o[pin_select_pkg::SLOT_PORT8] == $past(wr_data_i, 2)
  ) else $error("port 8 direction write did not reach the pins");

  a_port9_dir_out: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT9_DIR)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT9_DIR) |->
      ##1 (pin_oe_o[pin_select_pkg::SLOT_PORT9]
        & pin_select_pkg::DIR_MASK[pin_select_pkg::SLOT_PORT9])
        == ($past(wr_data_i, 2) & pin_select_pkg::DIR_MASK[pin_select_pkg::SLOT_PORT9])
  ) else $error("port 9 direction write did not reach the pins");

  a_strobe_func_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT5_FUNC)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT5_FUNC) |->
      ##1 func_sel_o[pin_select_pkg::SLOT_PORT5]
        == ($past(wr_data_i, 2) & pin_select_pkg::FUNC_MASK[pin_select_pkg::SLOT_PORT5])
  ) else $error("port 5 function write did not reach the pins");

  a_port8_func_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT8_FUNC)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT8_FUNC) |->
      ##1 func_sel_o[pin_select_pkg::SLOT_PORT8]
        == ($past(wr_data_i, 2) & pin_select_pkg::FUNC_MASK[pin_select_pkg::SLOT_PORT8])
  ) else $error("port 8 function write did not reach the pins");

  a_port9_func_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (!ext_rom && wr_i && addr_i == pin_select_pkg::OFF_PORT9_FUNC)
      ##1 !(wr_i && addr_i == pin_select_pkg::OFF_PORT9_FUNC) |->
      ##1 func_sel_o[pin_select_pkg::SLOT_PORT9]
        == ($past(wr_data_i, 2) & pin_select_pkg::FUNC_MASK[pin_select_pkg::SLOT_PORT9])
  ) else $error("port 9 function write did not reach the pins");

  a_strobe_drive_plain: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !ext_rom |->
      pin_oe_o[pin_select_pkg::SLOT_PORT5][1:0] == func_sel_o[pin_select_pkg::SLOT_PORT5][1:0]
  ) else $error("strobe pins drive without their role");

  a_func_selects_port: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !func_d[pin_select_pkg::SLOT_PORT8][0] |=>
      pin_do_o[pin_select_pkg::SLOT_PORT8][0]
        == $past(port_data_i[pin_select_pkg::SLOT_PORT8][0])
  ) else $error("plain port bit did not select the port data");

  a_reset_all_clear: assert property (
    @(posedge mclk_i)
    rst_i |=> (pin_oe_o == '0) && (func_sel_o == '0) && (pin_do_o == '0)
      && (rd_data_o == 8'h00)
  ) else $error("outputs not cleared by reset");

  a_port0_no_role: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !ext_rom |-> func_sel_o[pin_select_pkg::SLOT_PORT0] == 8'h00
  ) else $error("port 0 took a shared role in the plain part");

endmodule

/* tb/port_pin_function_select_tb.sv */
// Self-checking bench for the port pin direction and function-select block.
`timescale 1ns/1ps
module port_pin_function_select_tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic bus_dout_en_i = 1'b0;
  logic [8:0][7:0] port_data_i = {9{8'h3C}};
  logic [8:0][7:0] alt_data_i = {9{8'hC3}};
  logic [7:0] rd_data_o [2];
  logic [8:0][7:0] pin_do_o [2];
  logic [8:0][7:0] pin_oe_o [2];
  logic [8:0][7:0] func_sel_o [2];
  logic data_bus_mode_o [2];
  int err_count = 0;
  int tests_run = 0;

  // ==========================================================================
  // Two copies share every input: index 0 is the plain part, 1 the external-ROM one.
  for (genvar g = 0; g < 2; g++) begin : g_dut
    port_pin_function_select #(.EXT_ROM_VARIANT(g == 1)) uut (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .addr_i(addr_i),
      .wr_data_i(wr_data_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rd_data_o(rd_data_o[g]),
      .bus_dout_en_i(bus_dout_en_i),
      .port_data_i(port_data_i),
      .alt_data_i(alt_data_i),
      .pin_do_o(pin_do_o[g]),
      .pin_oe_o(pin_oe_o[g]),
      .func_sel_o(func_sel_o[g]),
      .data_bus_mode_o(data_bus_mode_o[g])
    );
  end

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // Bus tasks and comparison
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Leaves the caller in the one cycle where the read data stand.
  task automatic bus_read(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
  endtask

  // Every register holds v; the forced bus pins of the external part must ignore it.
  task automatic check_pins(input logic [7:0] v);
    logic [7:0] fn;
    logic [7:0] oe;
    logic [7:0] frc;
    logic [7:0] dv;
    repeat (3) @(posedge mclk_i);
    #1;
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < pin_select_pkg::NUM_SLOTS; s++) begin
        frc = (g == 1) ? pin_select_pkg::FORCE_MASK[s] : 8'h00;
        fn = (v & pin_select_pkg::FUNC_MASK[s]) | frc;
        oe = (v & pin_select_pkg::DIR_MASK[s]);
        oe = oe | (v & pin_select_pkg::FUNC_MASK[s] & ~pin_select_pkg::DIR_MASK[s]) | frc;
        if (g == 1 && s == pin_select_pkg::SLOT_PORT0) begin
          oe = {8{bus_dout_en_i}};
        end
        dv = (8'hC3 & fn) | (8'h3C & ~fn);
        chk("pin_oe_o", pin_oe_o[g][s], oe);
        chk("func_sel_o", func_sel_o[g][s], fn);
        chk("pin_do_o", pin_do_o[g][s], dv);
      end
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    wrap_up();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    logic [7:0] pats [3];
    logic [7:0] v;
    pats = '{8'hFF, 8'hA5, 8'h00};
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    check_pins(8'h00);
    chk("bus_mode", {7'h00, data_bus_mode_o[0]}, 8'h00);
    chk("bus_mode", {7'h00, data_bus_mode_o[1]}, 8'h01);
    $display("test reset state done");
    for (int p = 0; p < 3; p++) begin
      v = pats[p];
      for (int r = 0; r < pin_select_pkg::NUM_REGS; r++) begin
        bus_write(pin_select_pkg::REG_OFFSET[r], v);
      end
      // An unmapped write must leave every pin alone.
      bus_write(8'h03, ~v);
      check_pins(v);
      for (int r = 0; r < pin_select_pkg::NUM_REGS; r++) begin
        bus_read(pin_select_pkg::REG_OFFSET[r]);
        chk("rd_data_o", rd_data_o[0], 8'h00);
        chk("rd_data_o", rd_data_o[1], 8'h00);
      end
      bus_read(8'h03);
      chk("rd_data_o", rd_data_o[0], 8'h00);
      bus_read(pin_select_pkg::OFF_STATUS);
      chk("status", rd_data_o[0], {5'h00, |(v & 8'h03), |v, 1'b0});
      // The external part always shows its variant and both forced roles.
      chk("status_ext", rd_data_o[1], {5'h00, 3'h7});
      @(posedge mclk_i);
      #1;
      chk("rd_data_o", rd_data_o[0], 8'h00);
      $display("test pattern %h done", v);
    end
    @(posedge mclk_i);
    bus_dout_en_i <= 1'b1;
    check_pins(8'h00);
    @(posedge mclk_i);
    bus_dout_en_i <= 1'b0;
    check_pins(8'h00);
    $display("test data bus drive done");
    wrap_up();
  end
endmodule
